// file: verilog/cwwfs_defines.svh
// Timing, reset and encoding constants of the challenge window watchdog
`ifndef CWWFS_DEFINES_SVH
`define CWWFS_DEFINES_SVH

// ****************************************************************
// Clock and time base
// ****************************************************************
`define CWWFS_CLK_HZ 20000000
// One timer tick is half a millisecond so that a 1 ms window splits in two
`define CWWFS_TICK_US 500
`define CWWFS_TICK_CYCLES ((`CWWFS_CLK_HZ / 1000) * `CWWFS_TICK_US / 1000)
`define CWWFS_TICKS_PER_MS (1000 / `CWWFS_TICK_US)
`define CWWFS_INIT_WINDOW_MS 256
`define CWWFS_INIT_TICKS (`CWWFS_INIT_WINDOW_MS * `CWWFS_TICKS_PER_MS)
`define CWWFS_STUCK_MS 8000
`define CWWFS_STUCK_TICKS (`CWWFS_STUCK_MS * `CWWFS_TICKS_PER_MS)

// ****************************************************************
// Reset delay choices, in ticks
// ****************************************************************
`define CWWFS_RST_DLY_0 6'h02
`define CWWFS_RST_DLY_1 6'h06
`define CWWFS_RST_DLY_2 6'h10
`define CWWFS_RST_DLY_3 6'h20

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define CWWFS_CHAL_SEED 8'hB2
`define CWWFS_WIN_DEFAULT 4'h2
`define CWWFS_RST_ERR_START 3'h1
`define CWWFS_FINAL_LONG 3'h6
`define CWWFS_FINAL_SHORT 3'h2
`define CWWFS_INTER_LONG 3'h3
`define CWWFS_INTER_SHORT 3'h1
`define CWWFS_WD_ERR_STEP 4'h2
// Synchronised pin values at reset: key high, debug and reset request low
`define CWWFS_PIN_RESET 3'h4

`endif

// file: verilog/cwwfs_pkg.sv
// Types shared by the challenge window watchdog modules
package cwwfs_pkg;

    // Gray codes along select, delay, init, normal, deep, low power off
    typedef enum logic [2:0] {
        CWWFS_ST_SELECT = 3'h0,
        CWWFS_ST_RST_DELAY = 3'h1,
        CWWFS_ST_INIT = 3'h3,
        CWWFS_ST_NORMAL = 3'h2,
        CWWFS_ST_DEEP = 3'h6,
        CWWFS_ST_LOW_POWER_OFF = 3'h7
    } cwwfs_state_t;

endpackage

// file: verilog/cwwfs_win_if.sv
// Signals between the watchdog control and its window timer
interface cwwfs_win_if;
    logic tick;
    logic restart;
    logic init_mode;
    logic [11:0] period;
    logic open;
    logic timeout;

    modport ctrl (output tick, output restart, output init_mode, output period, input open, input timeout);
    modport timer (input tick, input restart, input init_mode, input period, output open, output timeout);
endinterface

// file: verilog/cwwfs_window_timer.sv
// Window timer: closed half, open half, timeout and the fully open init window
`include "cwwfs_defines.svh"
module cwwfs_window_timer #(
    parameter logic [11:0] INIT_TICKS = 12'(`CWWFS_INIT_TICKS)
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    cwwfs_win_if.timer win
);
    logic [11:0] cnt_ff;
    logic [11:0] per_ff;
    logic [11:0] limit;
    logic last;

    assign limit = win.init_mode ? INIT_TICKS : per_ff;
    assign last = win.tick && ((cnt_ff + 12'h001) >= limit);
    assign win.timeout = last && !win.restart;
    // Fixed 50% duty: the first half of each period is closed
    assign win.open = win.init_mode || (cnt_ff >= (per_ff >> 1));

    // The period only changes at a restart or a timeout
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_ff <= 12'h000;
            per_ff <= 12'h006;
        end
        else if (win.restart || last)
        begin
            cnt_ff <= 12'h000;
            per_ff <= win.period;
        end
        else if (win.tick)
        begin
            cnt_ff <= cnt_ff + 12'h001;
        end
    end
endmodule // cwwfs_window_timer

// file: verilog/cwwfs_watchdog.sv
// Challenge window watchdog with the fail-safe state handling around it
`include "cwwfs_defines.svh"
module cwwfs_watchdog #(
    parameter int TICK_CYCLES = `CWWFS_TICK_CYCLES,
    parameter int INIT_TICKS = `CWWFS_INIT_TICKS,
    parameter int STUCK_TICKS = `CWWFS_STUCK_TICKS
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic bist_ok_i,
    input wire logic answer_valid_i,
    input wire logic [7:0] answer_data_i,
    input wire logic seed_valid_i,
    input wire logic [7:0] seed_data_i,
    input wire logic window_write_i,
    input wire logic [3:0] window_sel_i,
    input wire logic wd_disable_i,
    input wire logic config_write_i,
    input wire logic [1:0] reset_delay_sel_i,
    input wire logic counter_limit_cfg_i,
    input wire logic [1:0] error_limit_sel_i,
    input wire logic [1:0] refresh_limit_sel_i,
    input wire logic stuck_timer_disable_i,
    input wire logic fault_i,
    input wire logic failsafe_release_i,
    input wire logic ext_reset_req_i,
    input wire logic debug_pin_i,
    input wire logic key_i,
    output logic mcu_reset_out_n_o,
    output logic failsafe_out_n_o,
    output logic regulators_on_o,
    output logic low_power_off_o,
    output logic deep_failsafe_o,
    output logic init_phase_o,
    output logic window_open_o,
    output logic debug_mode_o,
    output logic [7:0] challenge_value_o,
    output logic [2:0] wd_error_count_o,
    output logic [2:0] refresh_count_o,
    output logic [2:0] reset_error_count_o
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    cwwfs_pkg::cwwfs_state_t state_ff;
    cwwfs_pkg::cwwfs_state_t nxt_state;
    localparam logic [2:0] PIN_RST = `CWWFS_PIN_RESET;
    cwwfs_win_if win ();
    logic [2:0] pin_raw;
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] pin_ff;
    logic [13:0] tick_cnt_ff;
    logic tick;
    logic [7:0] chal_ff;
    logic [3:0] win_sel_ff;
    logic [1:0] rst_dly_sel_ff;
    logic limit_cfg_ff;
    logic [1:0] err_lim_sel_ff;
    logic [1:0] ref_lim_sel_ff;
    logic stuck_dis_ff;
    logic dbg_ff;
    logic [2:0] wd_err_ff;
    logic [2:0] ref_cnt_ff;
    logic [2:0] rst_err_ff;
    logic fs_ff;
    logic [5:0] dly_cnt_ff;
    logic [15:0] stuck_cnt_ff;
    logic in_init;
    logic in_norm;
    logic wd_active;
    logic ans_ok;
    logic good;
    logic bad;
    logic [2:0] wd_err_up;
    logic wd_trip;
    logic ref_wrap;
    logic ext_fault;
    logic rst_ev;
    logic [2:0] rst_err_inc;
    logic [2:0] final_val;
    logic [2:0] inter_val;
    logic deep_hit;
    logic stuck_hit;
    logic dly_done;
    logic waking;

    // ****************************************************************
    // Decoding functions
    // ****************************************************************
    // Window code to period in half-millisecond ticks
    function automatic logic [11:0] win_ticks(input logic [3:0] code);
        case (code)
            4'h0: win_ticks = 12'h002;
            4'h1: win_ticks = 12'h004;
            4'h2: win_ticks = 12'h006;
            4'h3: win_ticks = 12'h008;
            4'h4: win_ticks = 12'h00C;
            4'h5: win_ticks = 12'h010;
            4'h6: win_ticks = 12'h018;
            4'h7: win_ticks = 12'h020;
            4'h8: win_ticks = 12'h030;
            4'h9: win_ticks = 12'h040;
            4'hA: win_ticks = 12'h080;
            4'hB: win_ticks = 12'h100;
            4'hC: win_ticks = 12'h200;
            4'hD: win_ticks = 12'h400;
            4'hE: win_ticks = 12'h800;
            default: win_ticks = 12'h006;
        endcase
    endfunction

    // Shared by the watchdog error limit and the refresh counter limit
    function automatic logic [2:0] count_limit(input logic [1:0] sel);
        case (sel)
            2'h0: count_limit = 3'h6;
            2'h1: count_limit = 3'h4;
            2'h2: count_limit = 3'h2;
            default: count_limit = 3'h1;
        endcase
    endfunction

    function automatic logic [5:0] rst_delay(input logic [1:0] sel);
        case (sel)
            2'h0: rst_delay = `CWWFS_RST_DLY_0;
            2'h1: rst_delay = `CWWFS_RST_DLY_1;
            2'h2: rst_delay = `CWWFS_RST_DLY_2;
            default: rst_delay = `CWWFS_RST_DLY_3;
        endcase
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    assign pin_raw = {key_i, debug_pin_i, ext_reset_req_i};

    // A pin change counts only once the second and third stage agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    s1_ff[gi] <= PIN_RST[gi];
                    s2_ff[gi] <= PIN_RST[gi];
                    s3_ff[gi] <= PIN_RST[gi];
                    pin_ff[gi] <= PIN_RST[gi];
                end
                else
                begin
                    s1_ff[gi] <= pin_raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi])
                    begin
                        pin_ff[gi] <= s3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Tick prescaler and window timer
    // ****************************************************************
    assign tick = (tick_cnt_ff == 14'(TICK_CYCLES - 1));

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            tick_cnt_ff <= 14'h0000;
        else if (tick)
            tick_cnt_ff <= 14'h0000;
        else
            tick_cnt_ff <= tick_cnt_ff + 14'h0001;
    end

    assign win.tick = tick;
    assign win.init_mode = in_init;
    assign win.period = win_ticks(win_sel_ff);
    // Held in restart while inhibited, so enabling starts a fresh window
    // A state change is not a restart term: the timeout feeds the next state
    assign win.restart = !wd_active || answer_valid_i;

    cwwfs_window_timer #(
        .INIT_TICKS(12'(INIT_TICKS))
    ) u_timer (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .win(win)
    );

    // ****************************************************************
    // Refresh evaluation
    // ****************************************************************
    always_comb
    begin
        in_init = (state_ff == cwwfs_pkg::CWWFS_ST_INIT);
        in_norm = (state_ff == cwwfs_pkg::CWWFS_ST_NORMAL);
        wd_active = in_init || (in_norm && !wd_disable_i);
        ans_ok = (answer_data_i == ~chal_ff);
        good = wd_active && answer_valid_i && win.open && ans_ok;
        bad = wd_active && ((answer_valid_i && !(win.open && ans_ok)) || win.timeout);
        wd_err_up = (wd_err_ff > 3'h5) ? 3'h7 : 3'(wd_err_ff + `CWWFS_WD_ERR_STEP);
        wd_trip = in_norm && bad && (wd_err_up >= count_limit(err_lim_sel_ff)) && !dbg_ff;
        ref_wrap = in_norm && good && (ref_cnt_ff >= count_limit(ref_lim_sel_ff));
        ext_fault = fault_i || pin_ff[0];
        rst_ev = (in_init || in_norm) && (ext_fault || (in_init && bad) || wd_trip);
        rst_err_inc = (rst_err_ff == 3'h7) ? 3'h7 : rst_err_ff + 3'h1;
        final_val = limit_cfg_ff ? `CWWFS_FINAL_SHORT : `CWWFS_FINAL_LONG;
        inter_val = limit_cfg_ff ? `CWWFS_INTER_SHORT : `CWWFS_INTER_LONG;
        deep_hit = rst_ev && (rst_err_inc >= final_val);
        stuck_hit = !stuck_dis_ff && (stuck_cnt_ff > 16'(STUCK_TICKS));
        dly_done = (dly_cnt_ff >= rst_delay(rst_dly_sel_ff));
        waking = (state_ff == cwwfs_pkg::CWWFS_ST_LOW_POWER_OFF) && pin_ff[2];
    end

    // ****************************************************************
    // Safety state machine
    // ****************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            cwwfs_pkg::CWWFS_ST_SELECT:
                if (stuck_hit)
                    nxt_state = cwwfs_pkg::CWWFS_ST_DEEP;
                else if (bist_ok_i)
                    nxt_state = cwwfs_pkg::CWWFS_ST_RST_DELAY;
            cwwfs_pkg::CWWFS_ST_RST_DELAY:
                if (stuck_hit)
                    nxt_state = cwwfs_pkg::CWWFS_ST_DEEP;
                else if (dly_done && !ext_fault)
                    nxt_state = cwwfs_pkg::CWWFS_ST_INIT;
            cwwfs_pkg::CWWFS_ST_INIT:
                if (deep_hit)
                    nxt_state = cwwfs_pkg::CWWFS_ST_DEEP;
                else if (rst_ev)
                    nxt_state = cwwfs_pkg::CWWFS_ST_RST_DELAY;
                else if (good)
                    nxt_state = cwwfs_pkg::CWWFS_ST_NORMAL;
            cwwfs_pkg::CWWFS_ST_NORMAL:
                if (deep_hit)
                    nxt_state = cwwfs_pkg::CWWFS_ST_DEEP;
                else if (rst_ev)
                    nxt_state = cwwfs_pkg::CWWFS_ST_RST_DELAY;
            cwwfs_pkg::CWWFS_ST_DEEP:
                if (!pin_ff[2])
                    nxt_state = cwwfs_pkg::CWWFS_ST_LOW_POWER_OFF;
            cwwfs_pkg::CWWFS_ST_LOW_POWER_OFF:
                if (pin_ff[2])
                    nxt_state = cwwfs_pkg::CWWFS_ST_SELECT;
            default:
                nxt_state = cwwfs_pkg::CWWFS_ST_SELECT;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            state_ff <= cwwfs_pkg::CWWFS_ST_SELECT;
        else
            state_ff <= nxt_state;
    end

    // ****************************************************************
    // Configuration: fail-safe settings writable only in the init phase, window period at any time
    // ****************************************************************
    // Fail-safe settings are lost in low power off and return to defaults
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_dly_sel_ff <= 2'h0;
            limit_cfg_ff <= 1'b0;
            err_lim_sel_ff <= 2'h0;
            ref_lim_sel_ff <= 2'h0;
            stuck_dis_ff <= 1'b0;
        end
        else if (waking)
        begin
            rst_dly_sel_ff <= 2'h0;
            limit_cfg_ff <= 1'b0;
            err_lim_sel_ff <= 2'h0;
            ref_lim_sel_ff <= 2'h0;
            stuck_dis_ff <= 1'b0;
        end
        else if (in_init && config_write_i)
        begin
            rst_dly_sel_ff <= reset_delay_sel_i;
            limit_cfg_ff <= counter_limit_cfg_i;
            err_lim_sel_ff <= error_limit_sel_i;
            ref_lim_sel_ff <= refresh_limit_sel_i;
            stuck_dis_ff <= stuck_timer_disable_i;
        end
    end

    // The window period may be changed at any time
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            win_sel_ff <= `CWWFS_WIN_DEFAULT;
        else if (waking)
            win_sel_ff <= `CWWFS_WIN_DEFAULT;
        else if (window_write_i)
            win_sel_ff <= window_sel_i;
    end

    // Debug level is caught while the pins are scanned at start-up
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            dbg_ff <= 1'b0;
        else if (state_ff == cwwfs_pkg::CWWFS_ST_SELECT)
            dbg_ff <= pin_ff[1];
    end

    // ****************************************************************
    // Challenge shift register
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            chal_ff <= `CWWFS_CHAL_SEED;
        else if (waking)
            chal_ff <= `CWWFS_CHAL_SEED;
        else if (in_init && seed_valid_i)
            chal_ff <= seed_data_i;
        else if (good)
            chal_ff <= {chal_ff[6:0], chal_ff[7] ^ chal_ff[5] ^ chal_ff[4] ^ chal_ff[3]};
    end

    // ****************************************************************
    // Watchdog error and refresh counters
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            wd_err_ff <= 3'h0;
        else if (!(in_init || in_norm) || wd_trip)
            wd_err_ff <= 3'h0;
        else if (bad)
            wd_err_ff <= wd_err_up;
        else if (good && (wd_err_ff != 3'h0))
            wd_err_ff <= wd_err_ff - 3'h1;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ref_cnt_ff <= 3'h0;
        else if (bad || ref_wrap || !(in_init || in_norm))
            ref_cnt_ff <= 3'h0;
        else if (in_norm && good)
            ref_cnt_ff <= ref_cnt_ff + 3'h1;
    end

    // ****************************************************************
    // Reset error counter and fail-safe output
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_err_ff <= `CWWFS_RST_ERR_START;
        else if (waking)
            rst_err_ff <= `CWWFS_RST_ERR_START;
        else if (rst_ev)
            rst_err_ff <= rst_err_inc;
        else if (ref_wrap && (rst_err_ff != 3'h0))
            rst_err_ff <= rst_err_ff - 3'h1;
    end

    // Setting wins over a release request in the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            fs_ff <= 1'b1;
        else if (waking || (rst_ev && (rst_err_inc >= inter_val)) || deep_hit || stuck_hit)
            fs_ff <= 1'b1;
        else if (failsafe_release_i && (rst_err_ff == 3'h0) && !fault_i)
            fs_ff <= 1'b0;
    end

    // ****************************************************************
    // Reset delay and stuck-reset timers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            dly_cnt_ff <= 6'h00;
        else if (state_ff != cwwfs_pkg::CWWFS_ST_RST_DELAY)
            dly_cnt_ff <= 6'h00;
        else if (tick && (dly_cnt_ff != 6'h3F))
            dly_cnt_ff <= dly_cnt_ff + 6'h01;
    end

    // Runs in the select and reset delay states; cleared on release and re-armed per assertion
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            stuck_cnt_ff <= 16'h0000;
        else if (rst_ev || !((state_ff == cwwfs_pkg::CWWFS_ST_SELECT) ||
                              (state_ff == cwwfs_pkg::CWWFS_ST_RST_DELAY)))
            stuck_cnt_ff <= 16'h0000;
        else if (tick && (stuck_cnt_ff != 16'hFFFF))
            stuck_cnt_ff <= stuck_cnt_ff + 16'h0001;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Debug mode masks both pins so a halted MCU is never reset
    assign mcu_reset_out_n_o = dbg_ff || in_init || in_norm;
    assign failsafe_out_n_o = dbg_ff || !fs_ff;
    assign regulators_on_o = !((state_ff == cwwfs_pkg::CWWFS_ST_DEEP) ||
                               (state_ff == cwwfs_pkg::CWWFS_ST_LOW_POWER_OFF));
    assign low_power_off_o = (state_ff == cwwfs_pkg::CWWFS_ST_LOW_POWER_OFF);
    assign deep_failsafe_o = (state_ff == cwwfs_pkg::CWWFS_ST_DEEP);
    assign init_phase_o = in_init;
    assign window_open_o = wd_active && win.open;
    assign debug_mode_o = dbg_ff;
    assign challenge_value_o = chal_ff;
    assign wd_error_count_o = wd_err_ff;
    assign refresh_count_o = ref_cnt_ff;
    assign reset_error_count_o = rst_err_ff;
endmodule // cwwfs_watchdog

// file: sim/cwwfs_mcu_model.sv
// Behavioural MCU that answers the watchdog challenges
module cwwfs_mcu_model (
    input wire logic clk_i,
    input wire logic [1:0] mode_i,
    input wire logic window_open_i,
    input wire logic [7:0] challenge_value_i,
    output logic answer_valid_o,
    output logic [7:0] answer_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sent_ff = 1'b0;
    initial
    begin
        answer_valid_o = 1'b0;
        answer_data_o = 8'h00;
    end
    // Mode 0 stays silent, 1 answers right, 2 answers wrong; idle data toggles so no stale byte is seen
    always @(negedge clk_i)
    begin
        answer_valid_o <= 1'b0;
        answer_data_o <= ~answer_data_o;
        sent_ff <= sent_ff && window_open_i;
        if (window_open_i && !sent_ff && !answer_valid_o && mode_i != 2'h0)
        begin
            answer_valid_o <= 1'b1;
            answer_data_o <= (mode_i == 2'h1) ? ~challenge_value_i : challenge_value_i;
            sent_ff <= 1'b1;
        end
    end
endmodule // cwwfs_mcu_model

// file: sim/cwwfs_watchdog_assertions.sv
// Concurrent checks on the ports of the challenge window watchdog
module cwwfs_watchdog_assertions (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic answer_valid_i,
    input wire logic [7:0] answer_data_i,
    input wire logic wd_disable_i,
    input wire logic mcu_reset_out_n_o,
    input wire logic failsafe_out_n_o,
    input wire logic regulators_on_o,
    input wire logic low_power_off_o,
    input wire logic deep_failsafe_o,
    input wire logic init_phase_o,
    input wire logic window_open_o,
    input wire logic debug_mode_o,
    input wire logic [7:0] challenge_value_o,
    input wire logic [2:0] wd_error_count_o,
    input wire logic [2:0] refresh_count_o,
    input wire logic [2:0] reset_error_count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire good = answer_data_i == ~challenge_value_o;
    wire fb = ^(challenge_value_o & 8'hB8);
    // Normal running: reset released, outside init and debug, not inhibited
    wire nrm = mcu_reset_out_n_o && !init_phase_o && !debug_mode_o && !wd_disable_i;
    property p_debug; debug_mode_o |-> mcu_reset_out_n_o && failsafe_out_n_o; endproperty
    a_debug: assert property (p_debug) else $error("outputs asserted in debug");
    property p_regs; regulators_on_o != (deep_failsafe_o || low_power_off_o); endproperty
    a_regs: assert property (p_regs) else $error("regulators wrong");
    property p_deep; deep_failsafe_o && !debug_mode_o |-> !mcu_reset_out_n_o && !failsafe_out_n_o; endproperty
    a_deep: assert property (p_deep) else $error("deep outputs released");
    property p_good; answer_valid_i && window_open_o && good |=> challenge_value_o == {$past(challenge_value_o[6:0]), $past(fb)}; endproperty
    a_good: assert property (p_good) else $error("challenge not stepped");
    property p_bad; answer_valid_i && !good |=> $stable(challenge_value_o); endproperty
    a_bad: assert property (p_bad) else $error("challenge changed on bad answer");
    // A tripping error leaves normal running, which clears the error counter
    property p_err; nrm && answer_valid_i && !(good && window_open_o) |=> refresh_count_o == 3'h0 &&
        (!mcu_reset_out_n_o ||
        wd_error_count_o == ($past(wd_error_count_o) > 3'h5 ? 3'h7 : $past(wd_error_count_o) + 3'h2)); endproperty
    a_err: assert property (p_err) else $error("error counters wrong");
    property p_init_bad; init_phase_o && answer_valid_i && !good && !debug_mode_o |=>
        !mcu_reset_out_n_o && reset_error_count_o == $past(reset_error_count_o) + 3'h1; endproperty
    a_init_bad: assert property (p_init_bad) else $error("bad init answer");
    property p_init_good; init_phase_o && answer_valid_i && good |=> !init_phase_o && mcu_reset_out_n_o; endproperty
    a_init_good: assert property (p_init_good) else $error("good init answer");
    c_deep: cover property ($rose(deep_failsafe_o));
    c_low_power_off: cover property ($rose(low_power_off_o));
    c_zero: cover property (reset_error_count_o == 3'h0);
endmodule // cwwfs_watchdog_assertions
bind cwwfs_watchdog cwwfs_watchdog_assertions i_chk (.*);

// file: sim/tb_cwwfs_watchdog.sv
// Self-checking bench of the challenge window watchdog
module tb_cwwfs_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, reset_n_i = 1'b0, bist_ok_i = 1'b0, window_write_i = 1'b0, config_write_i = 1'b0;
    logic seed_valid_i = 1'b0, wd_disable_i = 1'b0, fault_i = 1'b0, failsafe_release_i = 1'b0;
    logic ext_reset_req_i = 1'b0, debug_pin_i = 1'b0, key_i = 1'b1, answer_valid_i;
    logic [7:0] cfg = 8'h00, seed_data_i = 8'h00, answer_data_i, challenge_value_o;
    logic [3:0] window_sel_i = 4'h0;
    logic [1:0] mode = 2'h0;
    logic mcu_reset_out_n_o, failsafe_out_n_o, regulators_on_o, low_power_off_o, deep_failsafe_o;
    logic init_phase_o, window_open_o, debug_mode_o;
    logic [2:0] wd_error_count_o, refresh_count_o, reset_error_count_o;
    int mismatches = 0, checked = 0, cyc = 0, n;
    always #25 clk_i = ~clk_i;
    // Short tick and stuck limit keep the run brief
    cwwfs_watchdog #(.TICK_CYCLES(10), .INIT_TICKS(512), .STUCK_TICKS(40)) i_dut (.*,
        .reset_delay_sel_i(cfg[1:0]), .error_limit_sel_i(cfg[3:2]), .refresh_limit_sel_i(cfg[5:4]),
        .counter_limit_cfg_i(cfg[6]), .stuck_timer_disable_i(cfg[7]));
    cwwfs_mcu_model i_mcu (.clk_i(clk_i), .mode_i(mode), .window_open_i(window_open_o),
        .challenge_value_i(challenge_value_o), .answer_valid_o(answer_valid_i), .answer_data_o(answer_data_i));
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
            mismatches++;
        end
    endtask
    task automatic t_start();
        bist_ok_i = 1'b1;
        for (n = 0; n < 400 && !init_phase_o; n++) @(negedge clk_i);
        chk("challenge", 8'hB2, challenge_value_o);
        chk("reset errors", 8'h01, reset_error_count_o);
        chk("failsafe", 8'h00, failsafe_out_n_o);
        chk("mcu reset", 8'h01, mcu_reset_out_n_o);
    endtask
    task automatic t_run();
        window_write_i = 1'b1;
        @(negedge clk_i);
        window_write_i = 1'b0;
        mode = 2'h1;
        for (n = 0; n < 6000 && init_phase_o; n++) @(negedge clk_i);
        chk("normal", 8'h01, mcu_reset_out_n_o);
        for (n = 0; n < 3000 && reset_error_count_o != 3'h0; n++) @(negedge clk_i);
        chk("reset errors", 8'h00, reset_error_count_o);
        chk("wd errors", 8'h00, wd_error_count_o);
        failsafe_release_i = 1'b1;
        @(negedge clk_i);
        failsafe_release_i = 1'b0;
        @(negedge clk_i);
        chk("failsafe", 8'h01, failsafe_out_n_o);
        wd_disable_i = 1'b1;
        repeat (100) @(negedge clk_i);
        chk("inhibited reset", 8'h01, mcu_reset_out_n_o);
        chk("inhibited errors", 8'h00, wd_error_count_o);
        wd_disable_i = 1'b0;
    endtask
    task automatic t_silent();
        mode = 2'h2;
        for (n = 0; n < 400 && wd_error_count_o == 3'h0; n++) @(negedge clk_i);
        chk("wrong answer errors", 8'h02, wd_error_count_o);
        mode = 2'h0;
        for (n = 0; n < 400 && mcu_reset_out_n_o; n++) @(negedge clk_i);
        chk("reset errors", 8'h01, reset_error_count_o);
        for (n = 0; n < 400 && !init_phase_o; n++) @(negedge clk_i);
        chk("released", 8'h01, mcu_reset_out_n_o);
    endtask
    task automatic t_deep();
        cfg = 8'h40;
        config_write_i = 1'b1;
        @(negedge clk_i);
        config_write_i = 1'b0;
        mode = 2'h2;
        for (n = 0; n < 200 && !deep_failsafe_o; n++) @(negedge clk_i);
        mode = 2'h0;
        chk("final count", 8'h02, reset_error_count_o);
        chk("regulators", 8'h00, regulators_on_o);
        key_i = 1'b0;
        for (n = 0; n < 50 && !low_power_off_o; n++) @(negedge clk_i);
        chk("low power off", 8'h01, low_power_off_o);
        key_i = 1'b1;
        for (n = 0; n < 600 && !init_phase_o; n++) @(negedge clk_i);
        chk("restart errors", 8'h01, reset_error_count_o);
        chk("restart challenge", 8'hB2, challenge_value_o);
        seed_data_i = 8'h5A;
        seed_valid_i = 1'b1;
        @(negedge clk_i);
        seed_valid_i = 1'b0;
        chk("seed", 8'h5A, challenge_value_o);
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        repeat (8) @(negedge clk_i);
        reset_n_i = 1'b1;
        t_start();
        t_run();
        t_silent();
        t_deep();
        summarize();
    end
endmodule // tb_cwwfs_watchdog
